// ---- src/sdi_tx_ctrl_pkg.sv ----
// Package for the transmit-side transceiver control block.
// Assumes a single fixed-frequency control clock; no bus, plain ports.
package sdi_tx_ctrl_pkg;
   // Nominal control clock, hertz
   localparam int unsigned CONTROL_CLOCK_HZ = 27000000;
   // Top bit index of the analog reset delay counter
   localparam int unsigned ANALOG_RESET_DELAY_TOP_BIT = 15;
   // Width of the lock delay counter
   localparam int unsigned LOCK_DELAY_COUNTER_WIDTH = 4;
   // Clock source selects for low and high divisor select
   localparam logic [1:0] CLKSEL_DIV_LOW = 2'h3;
   localparam logic [1:0] CLKSEL_DIV_HIGH = 2'h0;
   // Settle time between transmit reset release and user-ready, in nanoseconds
   localparam int unsigned USER_READY_SETTLE_NS = 500;
   localparam int unsigned USER_READY_SETTLE_CYC =
      (USER_READY_SETTLE_NS * (CONTROL_CLOCK_HZ / 1000) + 999999) / 1000000;
   localparam int unsigned TX_DATA_WIDTH = 20;
   localparam int unsigned TX_RATE_WIDTH = 3;
   localparam int unsigned CFG_DATA_WIDTH = 16;
   localparam logic [2:0] TX_RATE_RESET = 3'h0;
   localparam logic [15:0] CFG_DATA_RESET = 16'h0000;

   typedef struct packed {
      logic [CFG_DATA_WIDTH-1:0] wdata;
      logic en;
      logic we;
   } cfg_port_s;

   typedef enum logic [1:0] {
      ST_WAIT_LOCK = 2'b00,
      ST_LOCK_DELAY = 2'b01,
      ST_SETTLE = 2'b10,
      ST_RUN = 2'b11
   } seq_state_e;
endpackage : sdi_tx_ctrl_pkg

// ---- src/sdi_tx_ctrl.sv ----
// Transmit-side transceiver control: reset sequencing, rate and clock
// source selection, data and configuration port registers.
// Assumes PLL reset/lock arrive asynchronous; all other inputs on core_clk.
`timescale 1ns/1ps
module sdi_tx_ctrl
   import sdi_tx_ctrl_pkg::*;
#(
   parameter int unsigned control_clock_hz = CONTROL_CLOCK_HZ,
   parameter int unsigned analog_reset_delay_top_bit = ANALOG_RESET_DELAY_TOP_BIT,
   parameter int unsigned lock_delay_counter_width = LOCK_DELAY_COUNTER_WIDTH,
   parameter logic [1:0] clksel_div_low = CLKSEL_DIV_LOW,
   parameter logic [1:0] clksel_div_high = CLKSEL_DIV_HIGH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pll_reset,
   input wire logic pll_locked,
   input wire logic rate_div_sel,
   input wire logic [TX_RATE_WIDTH-1:0] rate_sel,
   input wire logic [TX_DATA_WIDTH-1:0] data_in,
   input wire sdi_tx_ctrl_pkg::cfg_port_s cfg_in,
   output logic [TX_DATA_WIDTH-1:0] tx_data,
   output logic tx_reset,
   output logic tx_user_ready,
   output logic tx_analog_reset,
   output logic [TX_RATE_WIDTH-1:0] tx_rate,
   output logic [1:0] tx_clk_sel,
   output sdi_tx_ctrl_pkg::cfg_port_s cfg_out,
   output logic tx_ready
);
   import sdi_tx_ctrl_pkg::*;

   localparam int unsigned SETTLE_CYC_RAW =
      (USER_READY_SETTLE_NS * (control_clock_hz / 1000) + 999999) / 1000000;
   localparam int unsigned SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

   logic [1:0] rst_sync_q;
   logic [1:0] lock_sync_q;
   logic pll_reset_s;
   logic pll_locked_s;
   seq_state_e state_q;
   logic [lock_delay_counter_width-1:0] lock_cnt_q;
   logic [7:0] settle_cnt_q;
   logic [analog_reset_delay_top_bit:0] pma_cnt_q;
   logic div_sel_q;
   logic restart;
   logic lock_done;
   logic settle_done;

   // Asynchronous pins pass two stages before use
   // Reset stage starts high so nothing runs before the PLL is seen
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rst_sync_q <= 2'h3;
      end else begin
         rst_sync_q <= {rst_sync_q[0], pll_reset};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lock_sync_q <= 2'h0;
      end else begin
         lock_sync_q <= {lock_sync_q[0], pll_locked};
      end
   end
   assign pll_reset_s = rst_sync_q[1];
   assign pll_locked_s = lock_sync_q[1];

   // Lost lock or PLL reset restarts from scratch
   assign restart = pll_reset_s || !pll_locked_s;
   assign lock_done = &lock_cnt_q;
   assign settle_done = (settle_cnt_q == SETTLE_LAST);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_WAIT_LOCK;
      end else if (restart) begin
         state_q <= ST_WAIT_LOCK;
      end else begin
         case (state_q)
            ST_WAIT_LOCK: begin
               state_q <= ST_LOCK_DELAY;
            end
            ST_LOCK_DELAY: begin
               if (lock_done) begin
                  state_q <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (settle_done) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_WAIT_LOCK;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lock_cnt_q <= '0;
      end else if (restart || state_q == ST_WAIT_LOCK) begin
         lock_cnt_q <= '0;
      end else if (state_q == ST_LOCK_DELAY && !lock_done) begin
         lock_cnt_q <= lock_cnt_q + 1'b1;
      end
   end

   // Settle counter between reset release and user-ready
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         settle_cnt_q <= 8'h00;
      end else if (restart) begin
         settle_cnt_q <= 8'h00;
      end else if (state_q == ST_SETTLE && !settle_done) begin
         settle_cnt_q <= settle_cnt_q + 8'h01;
      end
   end

   // Transmit reset released after lock delay
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_reset <= 1'b1;
      end else if (restart) begin
         tx_reset <= 1'b1;
      end else if (state_q == ST_LOCK_DELAY && lock_done) begin
         tx_reset <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_user_ready <= 1'b0;
      end else if (restart) begin
         tx_user_ready <= 1'b0;
      end else if (state_q == ST_SETTLE && settle_done) begin
         tx_user_ready <= 1'b1;
      end
   end

   // Ready drops while the analog side is held in reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_ready <= 1'b0;
      end else if (restart) begin
         tx_ready <= 1'b0;
      end else if (state_q == ST_RUN) begin
         tx_ready <= ~tx_analog_reset;
      end
   end

   // Previous divisor select, to spot a source change
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_sel_q <= 1'b0;
      end else begin
         div_sel_q <= rate_div_sel;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_clk_sel <= clksel_div_low;
      end else begin
         tx_clk_sel <= rate_div_sel ? clksel_div_high : clksel_div_low;
      end
   end

   // Analog reset held for full delay after source change
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pma_cnt_q <= '0;
         tx_analog_reset <= 1'b0;
      end else if (div_sel_q != rate_div_sel) begin
         pma_cnt_q <= '0;
         tx_analog_reset <= 1'b1;
      end else if (tx_analog_reset) begin
         if (pma_cnt_q[analog_reset_delay_top_bit]) begin
            tx_analog_reset <= 1'b0;
         end else begin
            pma_cnt_q <= pma_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_data <= '0;
      end else begin
         tx_data <= data_in;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_rate <= TX_RATE_RESET;
      end else begin
         tx_rate <= rate_sel;
      end
   end

   // Configuration write, write gated by enable
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_out <= '{wdata: CFG_DATA_RESET, en: 1'b0, we: 1'b0};
      end else begin
         cfg_out <= '{wdata: cfg_in.wdata, en: cfg_in.en, we: cfg_in.en & cfg_in.we};
      end
   end
endmodule : sdi_tx_ctrl

// ---- tb/sdi_tx_ctrl_sva.sv ----
// Port checker for the transmit control block.
// Assumes 20 MHz core_clk and a reduced analog reset delay.
`timescale 1ns/1ps
module sdi_tx_ctrl_sva
   import sdi_tx_ctrl_pkg::*;
#(
   parameter logic [1:0] clksel_div_low = 2'h3,
   parameter logic [1:0] clksel_div_high = 2'h0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pll_locked,
   input wire logic rate_div_sel,
   input wire sdi_tx_ctrl_pkg::cfg_port_s cfg_in,
   input wire sdi_tx_ctrl_pkg::cfg_port_s cfg_out,
   input wire logic tx_reset,
   input wire logic tx_user_ready,
   input wire logic tx_analog_reset,
   input wire logic [1:0] tx_clk_sel,
   input wire logic tx_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_sel_low; !rate_div_sel |=> tx_clk_sel == clksel_div_low; endproperty
   a_sel_low: assert property (p_sel_low) else $error("clock select low");
   property p_sel_high; rate_div_sel |=> tx_clk_sel == clksel_div_high; endproperty
   a_sel_high: assert property (p_sel_high) else $error("clock select high");
   property p_cfg; 1 |=> cfg_out == {$past(cfg_in.wdata), $past(cfg_in.en),
      $past(cfg_in.we & cfg_in.en)}; endproperty
   a_cfg: assert property (p_cfg) else $error("config port");
   property p_order; $fell(tx_reset) |-> !tx_user_ready [*8] ##[1:4] tx_user_ready; endproperty
   a_order: assert property (p_order) else $error("user ready order");
   property p_ready; $rose(tx_user_ready) && !tx_analog_reset |=> tx_ready; endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_pma; $changed(rate_div_sel) |=> tx_analog_reset [*8]; endproperty
   a_pma: assert property (p_pma) else $error("analog reset hold");
   property p_lock; $rose(pll_locked) |-> tx_reset [*8]; endproperty
   a_lock: assert property (p_lock) else $error("lock delay short");
   property p_loss; $fell(pll_locked) |-> ##[1:4] (tx_reset && !tx_user_ready); endproperty
   a_loss: assert property (p_loss) else $error("lock loss restart");
   c_ready: cover property ($rose(tx_ready));
   c_restart: cover property ($rose(tx_reset));
   c_pma: cover property ($fell(tx_analog_reset));
   c_we: cover property (cfg_out.we);
endmodule : sdi_tx_ctrl_sva
bind sdi_tx_ctrl sdi_tx_ctrl_sva #(.clksel_div_low(clksel_div_low),
   .clksel_div_high(clksel_div_high)) i_sdi_tx_ctrl_sva (.core_clk, .rst, .pll_locked,
   .rate_div_sel, .cfg_in, .cfg_out, .tx_reset, .tx_user_ready, .tx_analog_reset,
   .tx_clk_sel, .tx_ready);

// ---- tb/pll_pair_model.sv ----
// Two PLLs feeding the transmitter, merged for the control block.
// Assumes resets are driven before the first clock edge.
`timescale 1ns/1ps
module pll_pair_model (
   input wire logic clk,
   input wire logic quad_shared_pll_reset,
   input wire logic channel_local_pll_reset,
   output logic pll_reset,
   output logic pll_locked
);
   logic [3:0] q_q, c_q;
   // Channel PLL locks slower
   always_ff @(posedge clk) q_q <= quad_shared_pll_reset ? 4'h0 : q_q + {3'h0, !q_q[3]};
   always_ff @(posedge clk) c_q <= channel_local_pll_reset ? 4'h0 : c_q + {3'h0, c_q != 4'hf};
   assign pll_reset = quad_shared_pll_reset | channel_local_pll_reset;
   assign pll_locked = q_q[3] & (c_q == 4'hf);
endmodule : pll_pair_model

// ---- tb/test_sdi_tx_ctrl.sv ----
// Self-checking bench for the transmit control block.
// Assumes the PLL pair model and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
`define WAIT(c) begin for (k = 0; k < 300 && !(c); k++) @(negedge core_clk); \
   if (!(c)) begin num_errors++; finish_test(); end end
module test_sdi_tx_ctrl;
   import sdi_tx_ctrl_pkg::*;
   logic core_clk = 0, rst, pll_reset, pll_locked, rate_div_sel, q_rst, c_rst;
   logic tx_reset, tx_user_ready, tx_analog_reset, tx_ready;
   // Checks start one edge after reset is seen low
   logic live = 1'b0;
   logic [2:0] rate_sel, tx_rate, pr;
   logic [19:0] data_in, tx_data, pd;
   logic [1:0] tx_clk_sel;
   logic [31:0] r;
   cfg_port_s cfg_in, cfg_out, pc;
   int seed, k, i, num_errors = 0, checked = 0;
   initial forever #25 core_clk = !core_clk;
   pll_pair_model i_pll_pair_model (.clk(core_clk), .quad_shared_pll_reset(q_rst),
      .channel_local_pll_reset(c_rst), .pll_reset(pll_reset), .pll_locked(pll_locked));
   sdi_tx_ctrl #(.control_clock_hz(20000000), .analog_reset_delay_top_bit(4)) i_sdi_tx_ctrl (
      .core_clk(core_clk), .rst(rst), .pll_reset(pll_reset), .pll_locked(pll_locked),
      .rate_div_sel(rate_div_sel), .rate_sel(rate_sel), .data_in(data_in), .cfg_in(cfg_in),
      .tx_data(tx_data), .tx_reset(tx_reset), .tx_user_ready(tx_user_ready),
      .tx_analog_reset(tx_analog_reset), .tx_rate(tx_rate), .tx_clk_sel(tx_clk_sel),
      .cfg_out(cfg_out), .tx_ready(tx_ready));
   function automatic cfg_port_s exp_cfg(cfg_port_s c);
      return {c.wdata, c.en, c.we & c.en};
   endfunction : exp_cfg
   // Enable kept to single-cycle pulses
   always @(posedge core_clk) begin
      r = $random(seed);
      live <= !rst;
      pd <= data_in;
      pr <= rate_sel;
      pc <= cfg_in;
      data_in <= r[19:0];
      rate_sel <= r[22:20];
      cfg_in <= {r[15:0], r[30] & !cfg_in.en, r[31]};
   end
   always @(negedge core_clk) if (live) begin
      `CHK("data", pd, tx_data)
      `CHK("rate", pr, tx_rate)
      `CHK("cfg", exp_cfg(pc), cfg_out)
   end
   task finish_test;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      seed = 16;
      {rst, q_rst, c_rst, rate_div_sel, rate_sel, data_in, cfg_in} = {3'h7, 42'h0};
      repeat (3) @(posedge core_clk);
      `CHK("reset tx_reset", 1'h1, tx_reset)
      `CHK("reset clk_sel", CLKSEL_DIV_LOW, tx_clk_sel)
      rst <= 0;
      {q_rst, c_rst} <= 2'h0;
      `WAIT(tx_ready)
      `CHK("user ready", 1'h1, tx_user_ready)
      $display("lock sequence done");
      for (i = 0; i < 2; i++) begin
         @(posedge core_clk) rate_div_sel <= !rate_div_sel;
         repeat (2) @(negedge core_clk);
         `CHK("clk_sel", rate_div_sel ? CLKSEL_DIV_HIGH : CLKSEL_DIV_LOW, tx_clk_sel)
         `CHK("analog reset", 1'h1, tx_analog_reset)
         `WAIT(!tx_analog_reset)
         $display("clock source switch done");
      end
      for (i = 0; i < 2; i++) begin
         @(posedge core_clk) {q_rst, c_rst} <= i ? 2'h2 : 2'h1;
         `WAIT(tx_reset)
         `CHK("ready drop", 1'h0, tx_user_ready)
         @(posedge core_clk) {q_rst, c_rst} <= 2'h0;
         `WAIT(tx_ready)
         $display("pll reset restart done");
      end
      finish_test();
   end
endmodule : test_sdi_tx_ctrl
